// ---- rtl/pss_sequencer.sv ----
// Protection and startup sequencer: fault inputs, restart order and gate-drive gating.
// Assumes comparator results arrive asynchronously from the analog front end, while
// the gate, clamp-setting inputs come from oscillator logic on core_clk_i.
// A supply restart is seen as reset_n_i.
`timescale 1ns/1ps
module pss_sequencer #(
  parameter int unsigned DELAY_CYCLES   = pss_pkg::PFC_DELAY_CYC,
  parameter int unsigned ONESHOT_CYCLES = pss_pkg::SINK_SHOT_CYC,
  parameter int unsigned CLAMP_W        = pss_pkg::CLAMP_W_DEF
)(
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  // Comparator results, high means the condition named, except rail sense: high means rail good
  input  wire logic                rail_undervoltage_sense_i,
  input  wire logic                otp_trip_i,
  input  wire logic                latching_shutdown_input_i,
  input  wire logic                nonlatching_shutdown_input_i,
  input  wire logic                preheat_timer_input_i,
  input  wire logic                softstart_level_i,
  // Raw phases from the oscillator and the sync on-time setting
  input  wire logic                gate_low_i,
  input  wire logic                gate_high_i,
  input  wire logic [CLAMP_W-1:0]  sync_clamp_i,
  output logic                     low_gate_o,
  output logic                     high_gate_o,
  output logic                     low_sync_o,
  output logic                     high_sync_o,
  output logic                     hysteresis_sink_o,
  output logic                     rail_good_flag_o,
  output logic                     preheat_discharge_o,
  output logic                     softstart_discharge_o,
  output logic                     fb_timer_enable_o,
  output logic                     fault_latched_o,
  output pss_pkg::pss_cause_t      fault_cause_o,
  output pss_pkg::pss_state_t      state_o
);
  import pss_pkg::*;

  localparam int unsigned DW = $clog2(DELAY_CYCLES + 1);
  localparam int unsigned SW = $clog2(ONESHOT_CYCLES + 1);

  typedef struct packed {
    logic [SY_N-1:0]    sync1;
    logic [SY_N-1:0]    sync2;
    pss_state_t         state;
    pss_cause_t         cause;
    logic [DW-1:0]      delay_cnt;
    logic               shot_on;
    logic [SW-1:0]      shot_cnt;
    logic               low_seen;
    logic [CLAMP_W-1:0] on_cnt;
    logic               low_gate;
    logic               high_gate;
    logic               low_sync;
    logic               high_sync;
    logic               sink;
    logic               ph_dis;
    logic               ss_dis;
    logic               fb_en;
  } pss_regs_t;

  localparam pss_regs_t REGS_RST = '{
    state:   ST_OFF,
    cause:   CAUSE_NONE,
    shot_on: SHOT_ON_RST,
    sink:    1'b1,
    ph_dis:  1'b1,
    ss_dis:  1'b1,
    default: '0
  };

  logic [1:0] rst_sync_reg;
  logic       rst_n;

  pss_regs_t  r_reg;
  pss_regs_t  r_next;

  logic       rail_good;
  logic       otp_trip;
  logic       lat_trip;
  logic       nl_trip;
  logic       pulses_ok;

  pss_flt_if  rail_if ();
  pss_flt_if  otp_if ();
  pss_flt_if  lat_if ();

  // Release of reset is synchronised; assertion still acts at once
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  assign rail_if.raw = r_reg.sync2[SY_RAIL];
  assign otp_if.raw  = r_reg.sync2[SY_OTP];
  assign lat_if.raw  = r_reg.sync2[SY_LAT];

  pss_glitch_filter #(
    .CYCLES    (RAIL_FILT_CYC),
    .RST_LEVEL (1'b0)
  ) u_rail_filter (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .port_if   (rail_if)
  );

  pss_glitch_filter #(
    .CYCLES    (OTP_FILT_CYC),
    .RST_LEVEL (1'b0)
  ) u_otp_filter (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .port_if   (otp_if)
  );

  pss_glitch_filter #(
    .CYCLES    (LAT_FILT_CYC),
    .RST_LEVEL (1'b0)
  ) u_lat_filter (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .port_if   (lat_if)
  );

  assign rail_good = rail_if.clean;
  assign otp_trip  = otp_if.clean;
  assign lat_trip  = lat_if.clean;
  // No filter on this path: every cycle spent here eats the reaction budget
  assign nl_trip   = r_reg.sync2[SY_NL];

  always_comb
  begin
    r_next       = r_reg;
    r_next.sync1 = {softstart_level_i,
                    preheat_timer_input_i,
                    nonlatching_shutdown_input_i,
                    latching_shutdown_input_i,
                    otp_trip_i,
                    rail_undervoltage_sense_i};
    r_next.sync2 = r_reg.sync1;

    // Sink one-shot runs once per supply restart
    if (r_reg.shot_on)
    begin
      if (r_reg.shot_cnt == SW'(ONESHOT_CYCLES - 1))
        r_next.shot_on = 1'b0;
      else
        r_next.shot_cnt = r_reg.shot_cnt + 1'b1;
    end

    r_next.delay_cnt = '0;

    if (!rail_good)
    begin
      // Rail dropout also clears any latched fault
      r_next.state = ST_OFF;
      r_next.cause = CAUSE_NONE;
    end
    else if (nl_trip && r_reg.state != ST_LATCH)
    begin
      r_next.state = ST_OFF;
    end
    else
    begin
      unique case (r_reg.state)
        ST_OFF:
        begin
          // The latching comparator must have fallen back through its hysteresis.
          // The raw level is checked too: the filter restarts low after a supply cycle.
          if (!lat_trip && !r_reg.sync2[SY_LAT])
            r_next.state = ST_DELAY;
        end
        ST_DELAY:
        begin
          if (r_reg.delay_cnt == DW'(DELAY_CYCLES - 1))
            r_next.state = ST_PREHEAT;
          else
            r_next.delay_cnt = r_reg.delay_cnt + 1'b1;
        end
        ST_PREHEAT:
        begin
          if (r_reg.sync2[SY_PH])
            r_next.state = ST_SOFT;
        end
        ST_SOFT:
        begin
          if (lat_trip)
          begin
            r_next.state = ST_LATCH;
            r_next.cause = CAUSE_LATCHING;
          end
          else if (r_reg.sync2[SY_SS])
          begin
            r_next.state = ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (lat_trip)
          begin
            r_next.state = ST_LATCH;
            r_next.cause = CAUSE_LATCHING;
          end
          else if (otp_trip)
          begin
            r_next.state = ST_LATCH;
            r_next.cause = CAUSE_OTP;
          end
        end
        ST_LATCH:
        begin
          r_next.state = ST_LATCH;
        end
      endcase
    end

    // Use the next state so a trip blanks the very next output edge
    pulses_ok = r_next.state inside {ST_PREHEAT, ST_SOFT, ST_RUN};

    r_next.low_gate  = pulses_ok && gate_low_i;
    // High side waits for one low pulse to charge the bootstrap
    r_next.high_gate = pulses_ok && gate_high_i && !gate_low_i && r_reg.low_seen;

    if (!pulses_ok)
      r_next.low_seen = 1'b0;
    else if (r_next.low_gate)
      r_next.low_seen = 1'b1;

    // Sync outputs only ever cut a gate pulse short, never stretch it
    r_next.low_sync  = r_next.low_gate && (r_reg.on_cnt < sync_clamp_i);
    r_next.high_sync = r_next.high_gate && (r_reg.on_cnt < sync_clamp_i);

    if (!(r_next.low_gate || r_next.high_gate))
      r_next.on_cnt = '0;
    else if (r_reg.on_cnt != {CLAMP_W{1'b1}})
      r_next.on_cnt = r_reg.on_cnt + 1'b1;

    r_next.sink   = r_next.shot_on || !rail_good;
    r_next.ph_dis = !(r_next.state inside {ST_PREHEAT, ST_SOFT, ST_RUN});
    r_next.ss_dis = !(r_next.state inside {ST_SOFT, ST_RUN});
    r_next.fb_en  = (r_next.state == ST_RUN);
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= REGS_RST;
    else
      r_reg <= r_next;
  end

  assign low_gate_o            = r_reg.low_gate;
  assign high_gate_o           = r_reg.high_gate;
  assign low_sync_o            = r_reg.low_sync;
  assign high_sync_o           = r_reg.high_sync;
  assign hysteresis_sink_o     = r_reg.sink;
  assign rail_good_flag_o      = rail_good;
  assign preheat_discharge_o   = r_reg.ph_dis;
  assign softstart_discharge_o = r_reg.ss_dis;
  assign fb_timer_enable_o     = r_reg.fb_en;
  assign fault_latched_o       = (r_reg.state == ST_LATCH);
  assign fault_cause_o         = r_reg.cause;
  assign state_o               = r_reg.state;

endmodule

// ---- rtl/pss_pkg.sv ----
// Shared constants for the protection and startup sequencer.
// Assumes a single 40 MHz core clock; all times are turned into cycle counts here.
// Behaviour
// - Gate pulses blocked while rail sense is below 1 V, allowed above.
// - Rail sense comparator result is filtered for 20 us first.
// - Rail recovery after dropout runs delay, preheat, then soft-start.
// - Hysteresis sink on while rail below turn-on level, off when rail good.
// - Sink forced on for 50 ms after restart, then comparator decides.
// - Over-temperature input below 1.5 V latches the controller off.
// - Over-temperature input filtered for 50 us before it can latch.
// - Over-temperature input ignored during delay, preheat and soft-start.
// - Over-temperature latch clears only on supply cycling or rail retrigger.
// - Latching shutdown input, filtered 50 us, latches the controller off.
// - Latching shutdown input has no effect until preheat has finished.
// - Latching input must drop 50 mV below reference before restart allowed.
// - Latched shutdown clears on supply cycling or rail dropout and recovery.
// - Restart after latched shutdown runs delay, preheat, then soft-start.
// - Non-latching shutdown stops outputs within 120 ns.
// - Non-latching shutdown never masked by timers, live from supply turn-on.
// - Non-latching input release resumes through the full startup order.
// - First gate pulse after any restart goes to the low-side output.
// - Sync output on-time clamped by setting, never above gate on-time.
// - Startup begins with 100 ms delay, also after non-latching release.
// - Preheat ends and soft-start begins when preheat voltage exceeds 5 V.
// - Soft-start complete and feedback fault timer enabled at 1.9 V.
// - Non-latching shutdown trip stops all output pulses three core clock cycles after the input rises.
package pss_pkg;

  localparam int unsigned CLK_KHZ        = 40000;

  localparam int unsigned PFC_DELAY_MS   = 100;
  localparam int unsigned PFC_DELAY_CYC  = PFC_DELAY_MS * CLK_KHZ;
  localparam int unsigned SINK_SHOT_MS   = 50;
  localparam int unsigned SINK_SHOT_CYC  = SINK_SHOT_MS * CLK_KHZ;

  localparam int unsigned RAIL_FILT_US   = 20;
  localparam int unsigned RAIL_FILT_CYC  = (RAIL_FILT_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned OTP_FILT_US    = 50;
  localparam int unsigned OTP_FILT_CYC   = (OTP_FILT_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned LAT_FILT_US    = 50;
  localparam int unsigned LAT_FILT_CYC   = (LAT_FILT_US * CLK_KHZ + 999) / 1000;

  // Longest allowed reaction of the non-latching path, rounded down
  localparam int unsigned NL_REACT_NS    = 120;
  localparam int unsigned NL_REACT_CYC   = (NL_REACT_NS * CLK_KHZ) / 1000000;

  localparam int unsigned CLAMP_W_DEF    = 16;

  // Synchroniser bit positions
  localparam int unsigned SY_RAIL        = 0;
  localparam int unsigned SY_OTP         = 1;
  localparam int unsigned SY_LAT         = 2;
  localparam int unsigned SY_NL          = 3;
  localparam int unsigned SY_PH          = 4;
  localparam int unsigned SY_SS          = 5;
  localparam int unsigned SY_N           = 6;

  localparam logic        SHOT_ON_RST    = 1'b1;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_DELAY,
    ST_PREHEAT,
    ST_SOFT,
    ST_RUN,
    ST_LATCH
  } pss_state_t;

  typedef enum logic [1:0] {
    CAUSE_NONE,
    CAUSE_LATCHING,
    CAUSE_OTP
  } pss_cause_t;

endpackage

// ---- rtl/pss_flt_if.sv ----
// Carrier between the sequencer and one of its input noise filters.
// Assumes both ends sit on core_clk_i.
`timescale 1ns/1ps
interface pss_flt_if;
  logic raw;
  logic clean;
  modport filter (input raw, output clean);
  modport user   (output raw, input clean);
endinterface

// ---- rtl/pss_glitch_filter.sv ----
// Noise filter: the output follows the input only after it has differed for CYCLES clocks.
// Assumes the input is already synchronised to clk_i.
`timescale 1ns/1ps
module pss_glitch_filter #(
  parameter int unsigned CYCLES    = 16,
  parameter logic        RST_LEVEL = 1'b0
)(
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  pss_flt_if.filter   port_if
);
  import pss_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic          level;
    logic [CW-1:0] cnt;
  } pss_flt_regs_t;

  localparam pss_flt_regs_t FLT_RST = '{level: RST_LEVEL, cnt: '0};

  pss_flt_regs_t r_reg;
  pss_flt_regs_t r_next;

  always_comb
  begin
    r_next = r_reg;
    // Any agreement restarts the count, so a single spike never gets through
    if (port_if.raw == r_reg.level)
      r_next.cnt = '0;
    else if (r_reg.cnt == CW'(CYCLES - 1))
    begin
      r_next.level = port_if.raw;
      r_next.cnt   = '0;
    end
    else
      r_next.cnt = r_reg.cnt + 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r_reg <= FLT_RST;
    else
      r_reg <= r_next;
  end

  assign port_if.clean = r_reg.level;

endmodule

// ---- tb/pss_partner.sv ----
// Far side: preheat and soft-start capacitors plus oscillator phases.
// Assumes the sequencer's clock; outputs change at the rising edge.
`timescale 1ns/1ps
module pss_partner #(
  parameter int CAP_CYCLES = 2500
)(
  input  wire logic clk_i,
  input  wire logic preheat_discharge_i,
  input  wire logic softstart_discharge_i,
  output logic      preheat_high_o,
  output logic      softstart_high_o,
  output logic      gate_low_o,
  output logic      gate_high_o
);
  int         ph_cnt = 0;
  int         ss_cnt = 0;
  logic [3:0] osc    = 4'h0;
  // Capacitors only charge while their discharge switch is open
  always @(posedge clk_i)
  begin
    ph_cnt <= preheat_discharge_i ? 0 : ((ph_cnt < CAP_CYCLES) ? ph_cnt + 1 : ph_cnt);
    ss_cnt <= softstart_discharge_i ? 0 : ((ss_cnt < CAP_CYCLES) ? ss_cnt + 1 : ss_cnt);
    preheat_high_o <= ph_cnt >= CAP_CYCLES;
    softstart_high_o <= ss_cnt >= CAP_CYCLES;
    osc <= (osc == 4'h9) ? 4'h0 : osc + 4'h1;
    // A dead cycle between phases keeps the two gates apart
    gate_low_o <= osc < 4'h4;
    gate_high_o <= (osc > 4'h4) && (osc < 4'h9);
  end
endmodule

// ---- tb/pss_properties.sv ----
// Concurrent checks on the sequencer's top ports.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ps
module pss_properties
  import pss_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES   = 50,
  parameter int unsigned ONESHOT_CYCLES = 30,
  parameter int unsigned CLAMP_W        = 16
)(
  input wire logic core_clk_i, reset_n_i, rail_undervoltage_sense_i, otp_trip_i, latching_shutdown_input_i,
  input wire logic nonlatching_shutdown_input_i, preheat_timer_input_i, softstart_level_i, gate_low_i,
  input wire logic gate_high_i, low_gate_o, high_gate_o, low_sync_o, high_sync_o, hysteresis_sink_o,
  input wire logic rail_good_flag_o, preheat_discharge_o, softstart_discharge_o, fb_timer_enable_o,
  input wire logic fault_latched_o,
  input wire logic [CLAMP_W-1:0] sync_clamp_i,
  input wire pss_cause_t fault_cause_o,
  input wire pss_state_t state_o
);
  logic [31:0] age_reg, dly_reg, sync_reg;
  logic        seen_low_reg;
  logic        en;
  logic        ss_open;
  assign en = state_o inside {ST_PREHEAT, ST_SOFT, ST_RUN};
  assign ss_open = state_o inside {ST_SOFT, ST_RUN};
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      age_reg      <= '0;
      dly_reg      <= '0;
      sync_reg     <= '0;
      seen_low_reg <= 1'b0;
    end
    else
    begin
      age_reg      <= (age_reg < ONESHOT_CYCLES + 8) ? age_reg + 32'd1 : age_reg;
      dly_reg      <= (state_o == ST_DELAY) ? dly_reg + 32'd1 : '0;
      sync_reg     <= (low_sync_o || high_sync_o) ? sync_reg + 32'd1 : '0;
      seen_low_reg <= en & (seen_low_reg | low_gate_o);
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_nl_trip;
    $rose(nonlatching_shutdown_input_i) ##1 nonlatching_shutdown_input_i [*3];
  endsequence
  sequence s_delay_done;
    state_o == ST_DELAY ##1 state_o == ST_PREHEAT;
  endsequence
  AST_GATES_IDLE: assert property (!en && !$past(en) |-> !low_gate_o && !high_gate_o)
    else $error("gate active outside enabled states");
  AST_RAIL_OFF: assert property (!rail_good_flag_o [*2] |-> state_o == ST_OFF && hysteresis_sink_o)
    else $error("rail low but not off or sink off");
  AST_SINK_SHOT: assert property (age_reg < ONESHOT_CYCLES |-> hysteresis_sink_o)
    else $error("sink off during one-shot");
  AST_SINK_FREE: assert property (age_reg == ONESHOT_CYCLES + 8 && rail_good_flag_o [*2] |-> !hysteresis_sink_o)
    else $error("sink on with rail good");
  AST_NL_STOP: assert property (s_nl_trip |-> !low_gate_o && !high_gate_o)
    else $error("gates still on after fast shutdown");
  AST_DELAY_LEN: assert property (s_delay_done |-> dly_reg == DELAY_CYCLES)
    else $error("startup delay length wrong");
  AST_ORDER: assert property ($changed(state_o) |-> (state_o != ST_DELAY || $past(state_o) == ST_OFF)
    && (state_o != ST_PREHEAT || $past(state_o) == ST_DELAY) && (state_o != ST_SOFT || $past(state_o) == ST_PREHEAT)
    && (state_o != ST_RUN || $past(state_o) == ST_SOFT))
    else $error("illegal state step");
  AST_LATCH_SRC: assert property (state_o == ST_SOFT ##1 state_o == ST_LATCH |-> ##[0:1]
    fault_cause_o == CAUSE_LATCHING)
    else $error("latch cause wrong out of soft-start");
  AST_LOW_FIRST: assert property (high_gate_o |-> seen_low_reg)
    else $error("high gate before low gate");
  AST_SYNC_CLAMP: assert property ((low_sync_o || high_sync_o) |-> sync_reg < sync_clamp_i
    && (!low_sync_o || low_gate_o) && (!high_sync_o || high_gate_o))
    else $error("sync output beyond clamp or gate");
  AST_FB_RUN: assert property (fb_timer_enable_o |-> state_o == ST_RUN || $past(state_o) == ST_RUN)
    else $error("fault timer enabled outside run");
  AST_DISCHARGE: assert property (preheat_discharge_o != en && softstart_discharge_o != ss_open)
    else $error("discharge switch wrong for state");
endmodule
bind pss_sequencer pss_properties #(.DELAY_CYCLES(DELAY_CYCLES), .ONESHOT_CYCLES(ONESHOT_CYCLES),
  .CLAMP_W(CLAMP_W)) u_props (.*);

// ---- tb/protection_startup_sequencer_tb.sv ----
// Self-checking bench for the sequencer with the capacitor and oscillator model.
// Assumes short startup counts so the run stays small.
`timescale 1ns/1ps
module protection_startup_sequencer_tb;
  import pss_pkg::*;
  localparam int DLY = 50;
  logic clk, rst_n, rail, otp, lat, nl, ph, ss, gl, gh;
  logic low_g, high_g, low_s, high_s, sink, good, ph_dis, ss_dis, fb, flt;
  logic [15:0] clamp = 16'h0003;
  pss_cause_t cause;
  pss_state_t st;
  int n_mismatch = 0;
  int checks_done = 0;
  pss_sequencer #(.DELAY_CYCLES(DLY), .ONESHOT_CYCLES(30)) u_dut (.core_clk_i(clk), .reset_n_i(rst_n),
    .rail_undervoltage_sense_i(rail), .otp_trip_i(otp), .latching_shutdown_input_i(lat),
    .nonlatching_shutdown_input_i(nl), .preheat_timer_input_i(ph), .softstart_level_i(ss), .gate_low_i(gl),
    .gate_high_i(gh), .sync_clamp_i(clamp), .low_gate_o(low_g), .high_gate_o(high_g), .low_sync_o(low_s),
    .high_sync_o(high_s), .hysteresis_sink_o(sink), .rail_good_flag_o(good), .preheat_discharge_o(ph_dis),
    .softstart_discharge_o(ss_dis), .fb_timer_enable_o(fb), .fault_latched_o(flt), .fault_cause_o(cause),
    .state_o(st));
  pss_partner u_far (.clk_i(clk), .preheat_discharge_i(ph_dis), .softstart_discharge_i(ss_dis),
    .preheat_high_o(ph), .softstart_high_o(ss), .gate_low_o(gl), .gate_high_o(gh));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait so a stuck machine is reported instead of hanging
  task automatic wait_st(input pss_state_t s, input int lim);
    int i;
    i = 0;
    while (st !== s && i < lim)
    begin
      cyc(1);
      i++;
    end
    chk("state", st, s);
  endtask
  task automatic t_boot;
    int i;
    chk("state", st, ST_OFF);
    chk("sink", sink, 1'b1);
    @(posedge clk) rail <= 1'b1;
    cyc(400);
    chk("sink", sink, 1'b1);
    wait_st(ST_DELAY, 900);
    cyc(2);
    chk("sink", sink, 1'b0);
    i = 2;
    while (st === ST_DELAY && i < 100)
    begin
      cyc(1);
      i++;
    end
    chk("delay", i, DLY);
    chk("discharge", {ph_dis, ss_dis}, 2'b01);
    for (i = 0; i < 20 && !low_g && !high_g; i++) cyc(1);
    chk("low first", {low_g, high_g, low_s}, 3'b101);
    // Sync must be gone three cycles after the pulse began, whatever the gate does
    cyc(3);
    chk("clamp", low_s, 1'b0);
    wait_st(ST_SOFT, 3000);
    chk("ss discharge", ss_dis, 1'b0);
    wait_st(ST_RUN, 3000);
    cyc(1);
    chk("fb enable", fb, 1'b1);
    $display("Test boot done");
  endtask
  task automatic t_rail;
    @(posedge clk) rail <= 1'b0;
    cyc(400);
    @(posedge clk) rail <= 1'b1;
    cyc(900);
    chk("state", st, ST_RUN);
    @(posedge clk) rail <= 1'b0;
    wait_st(ST_OFF, 900);
    cyc(3);
    chk("off outputs", {good, low_g, high_g, low_s, high_s, sink, ph_dis, ss_dis}, 8'h07);
    @(posedge clk) rail <= 1'b1;
    wait_st(ST_RUN, 6000);
    $display("Test rail done");
  endtask
  task automatic t_nl;
    @(posedge clk) nl <= 1'b1;
    cyc(3);
    chk("gates", {low_g, high_g}, 2'b00);
    chk("state", st, ST_OFF);
    @(posedge clk) nl <= 1'b0;
    wait_st(ST_DELAY, 6);
    wait_st(ST_PREHEAT, DLY + 2);
    $display("Test fast shutdown done");
  endtask
  task automatic t_otp;
    // Restart with the over-temperature input already tripped: it must wait for run
    @(posedge clk) nl <= 1'b1;
    cyc(3);
    @(posedge clk) nl <= 1'b0;
    otp <= 1'b1;
    cyc(2100);
    chk("latched", flt, 1'b0);
    wait_st(ST_RUN, 6000);
    wait_st(ST_LATCH, 4);
    cyc(2);
    chk("cause", cause, CAUSE_OTP);
    @(posedge clk) otp <= 1'b0;
    nl <= 1'b1;
    cyc(3000);
    chk("state", st, ST_LATCH);
    @(posedge clk) nl <= 1'b0;
    rail <= 1'b0;
    wait_st(ST_OFF, 900);
    chk("cause", cause, CAUSE_NONE);
    @(posedge clk) rail <= 1'b1;
    wait_st(ST_RUN, 6000);
    $display("Test otp done");
  endtask
  task automatic t_lat;
    @(posedge clk) lat <= 1'b1;
    cyc(1000);
    @(posedge clk) lat <= 1'b0;
    cyc(2100);
    chk("state", st, ST_RUN);
    t_nl();
    @(posedge clk) lat <= 1'b1;
    cyc(2100);
    chk("state", st, ST_PREHEAT);
    wait_st(ST_LATCH, 3000);
    cyc(2);
    chk("cause", cause, CAUSE_LATCHING);
    @(posedge clk) rst_n <= 1'b0;
    cyc(2);
    @(posedge clk) rst_n <= 1'b1;
    cyc(1500);
    chk("state", st, ST_OFF);
    @(posedge clk) lat <= 1'b0;
    wait_st(ST_DELAY, 2100);
    wait_st(ST_RUN, 6000);
    $display("Test latching done");
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {rst_n, rail, otp, lat, nl} = 5'h00;
    cyc(12);
    @(posedge clk) rst_n <= 1'b1;
    cyc(2);
    t_boot();
    t_rail();
    t_nl();
    wait_st(ST_RUN, 6000);
    t_otp();
    t_lat();
    final_report();
  end
  initial
  begin
    #(25 * 100000);
    n_mismatch++;
    final_report();
  end
endmodule
